// ==== rtl/mfr_read_ctrl.sv ====
`default_nettype none
// Behaviour
// [R1] one enable and one read clock per fifo
// [R2] fifos hold 1K words of 32 bits
// [R3] fifo pops on rclk rise with enable low
// [R4] enable first, read clock one cycle later
// [R5] two cycles of settle after read clock
// [R6] four wait states before first word
// [R7] enable only after bus turned to read
// [R8] bursts use 4,1,1,1 wait profile
// [R9] each fifo decodes a 1024-byte window
// [R10] refresh clocks all fifos after strobe; pulses only while all enables stay high, none on reads that turn at once
// [R11] refresh pulse keeps read enable high
// [R12] fifo flags change only on rclk rise
// [R13] flags readable, active low, per fifo
// [R14] software bursts only when half full
// [R15] enable held for the whole access
// [R16] one ready acknowledge per word
module mfr_read_ctrl import mfr_pkg::*; (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic address_strobe_n_i,
	input wire logic [31:0] addr_i,
	input wire logic write_not_read_i,
	input wire logic burst_last_i,
	input wire logic [2:0] fifo_region_sel_i,
	input wire logic slow_bus_direction_i,
	input wire logic [31:0] slow_data_i,
	input wire logic [2:0] fifo_empty_flag_n_i,
	input wire logic [2:0] fifo_half_full_flag_n_i,
	input wire logic [2:0] fifo_full_flag_n_i,
	input wire logic word_ready_i,
	output logic [2:0] segment_fifo_output_enable_n_o,
	output logic [2:0] segment_fifo_read_clock_o,
	output logic ready_n_o,
	output logic [31:0] word_data_o,
	output logic word_valid_o,
	output logic [2:0] fifo_empty_flag_n_o,
	output logic [2:0] fifo_half_full_flag_n_o,
	output logic [2:0] fifo_full_flag_n_o,
	output logic busy_o
);
	typedef struct packed {
		mfr_state_e st;
		logic [2:0] cnt;
		logic [2:0] sel;
		logic [1:0] ref_cnt;
		logic ref_act;
		logic [2:0] oe_n;
		logic [2:0] rclk;
		logic rdy_n;
		logic first;
		logic [9:0] word_addr;
		logic [1:0] left;
		logic [4:0] fill;
	} mfr_ctl_s;
	mfr_ctl_s s_r, s_nxt;

	// two-flop synchronisers for every pin input
	logic [13:0] pin_m_r, pin_s_r;
	logic ads_n, dir, last, wr;
	logic [2:0] hit;
	logic [31:0] addr_m_r, addr_s_r;
	logic [8:0] flg_m_r, flg_s_r;
	logic [31:0] dat_m_r, dat_s_r;
	logic buf_in_ready;
	logic cap_valid;
	logic issue, room;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_m_r <= 14'h0001;
			pin_s_r <= 14'h0001;
			addr_m_r <= 32'h0;
			addr_s_r <= 32'h0;
			flg_m_r <= 9'h000;
			flg_s_r <= 9'h000;
			dat_m_r <= 32'h0;
			dat_s_r <= 32'h0;
		end else begin
			pin_m_r <= {7'h00, slow_bus_direction_i, fifo_region_sel_i,
				burst_last_i, write_not_read_i, address_strobe_n_i};
			pin_s_r <= pin_m_r;
			addr_m_r <= addr_i;
			addr_s_r <= addr_m_r;
			flg_m_r <= {fifo_full_flag_n_i, fifo_half_full_flag_n_i,
				fifo_empty_flag_n_i};
			flg_s_r <= flg_m_r;
			dat_m_r <= slow_data_i;
			dat_s_r <= dat_m_r;
		end
	end

	assign ads_n = pin_s_r[0];
	assign wr = pin_s_r[1];
	assign last = pin_s_r[2];
	assign hit = pin_s_r[5:3];
	assign dir = pin_s_r[6];

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdy_n = 1'b1;
		// [R16] the acknowledged word is pushed as ready stands
		cap_valid = !s_r.rdy_n;
		issue = 1'b0;
		// a slot is reserved per pop so a burst cannot overrun the buffer
		room = s_r.fill < 5'(MFR_BUF_DEPTH);
		// [R10] refresh pulse timing
		if (!ads_n) begin
			s_nxt.ref_cnt = 2'h1;
			s_nxt.ref_act = 1'b1;
		end else if (s_r.ref_act) begin
			s_nxt.ref_cnt = s_r.ref_cnt + 2'h1;
			if (s_r.ref_cnt == MFR_REFRESH_DELAY) begin
				s_nxt.ref_act = 1'b0;
			end
		end
		s_nxt.rclk = 3'h0;
		unique case (s_r.st)
			MFR_IDLE: begin
				s_nxt.oe_n = MFR_OE_RST;
				// [R9] window decode selects the fifo
				if (!ads_n && !wr && hit != 3'h0) begin
					s_nxt.sel = hit;
					s_nxt.word_addr = addr_s_r[MFR_WINDOW_LSB-1:0];
					// a burst is always four words, a single read one
					s_nxt.left = last ? 2'h0 : 2'h3;
					s_nxt.first = 1'b1;
					s_nxt.st = MFR_TURN;
				end
			end
			MFR_TURN: begin
				// [R7] hold off until bus turned to read
				if (dir == 1'b0 && room) begin
					s_nxt.oe_n = ~s_r.sel;
					s_nxt.cnt = 3'h0;
					s_nxt.st = MFR_WAIT;
				end
			end
			MFR_WAIT: begin
				s_nxt.cnt = s_r.cnt + 3'h1;
				// [R4] read clock one cycle after enable
				if (s_r.cnt == 3'h0) begin
					if (room) begin
						issue = 1'b1;
						s_nxt.cnt = MFR_RCLK_DELAY;
					end else begin
						s_nxt.cnt = 3'h0;
					end
				end
				// [R5] [R6] [R8] ack two cycles after the pop
				if (s_r.cnt == MFR_SETTLE_CYCLES) begin
					// [R16] acknowledge this word
					s_nxt.rdy_n = 1'b0;
					s_nxt.first = 1'b0;
					s_nxt.word_addr = s_r.word_addr + 10'h004;
					s_nxt.cnt = 3'h0;
					if (s_r.left == 2'h0) begin
						s_nxt.st = MFR_DONE;
					end else begin
						s_nxt.left = s_r.left - 2'h1;
						// next word popped as this one is acked
						if (room) begin
							issue = 1'b1;
							s_nxt.cnt = MFR_RCLK_DELAY;
						end
					end
				end
			end
			MFR_ACK: begin
				s_nxt.st = MFR_DONE;
			end
			MFR_DONE: begin
				// [R15] enable released only as access ends
				s_nxt.oe_n = MFR_OE_RST;
				s_nxt.st = MFR_IDLE;
			end
			default: begin
				s_nxt.st = MFR_IDLE;
			end
		endcase
		if (issue) begin
			s_nxt.rclk = s_r.sel;
		end
		s_nxt.fill = s_r.fill + {4'h0, issue}
			- {4'h0, word_valid_o && word_ready_i};
		// [R11] refresh pulse only while enables stay high
		if (s_r.ref_act && s_r.ref_cnt == MFR_REFRESH_DELAY - 2'h1
				&& s_nxt.oe_n == MFR_OE_RST && s_r.oe_n == MFR_OE_RST) begin
			s_nxt.rclk = 3'h7;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{st: MFR_IDLE, cnt: 3'h0, sel: 3'h0, ref_cnt: 2'h0,
				ref_act: 1'b0, oe_n: MFR_OE_RST, rclk: MFR_RCLK_RST,
				rdy_n: 1'b1, first: 1'b0, word_addr: 10'h000, left: 2'h0,
				fill: 5'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	// [R1] six control outputs, all from flops
	assign segment_fifo_output_enable_n_o = s_r.oe_n;
	assign segment_fifo_read_clock_o = s_r.rclk;
	// [R16] ready straight from its flop
	assign ready_n_o = s_r.rdy_n;
	// [R13] flags from the input port presented after the synchroniser
	assign fifo_empty_flag_n_o = flg_s_r[2:0];
	assign fifo_half_full_flag_n_o = flg_s_r[5:3];
	assign fifo_full_flag_n_o = flg_s_r[8:6];
	assign busy_o = s_r.st != MFR_IDLE;

	// [R2] each acknowledged word is kept for the consumer
	mfr_word_buf #(
		.WIDTH(MFR_DATA_W),
		.DEPTH(MFR_BUF_DEPTH)
	) u_buf (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.in_data_i(dat_s_r),
		.in_valid_i(cap_valid),
		.in_ready_o(buf_in_ready),
		.out_data_o(word_data_o),
		.out_valid_o(word_valid_o),
		.out_ready_i(word_ready_i)
	);
endmodule
`default_nettype wire

// ==== common/mfr_pkg.sv ====
`default_nettype none
package mfr_pkg;
	localparam int unsigned MFR_NUM_FIFOS = 3;
	localparam int unsigned MFR_DATA_W = 32;
	localparam int unsigned MFR_BUF_DEPTH = 16;
	// each external fifo decodes a 1024-byte window
	localparam int unsigned MFR_WINDOW_BYTES = 1024;
	localparam int unsigned MFR_WINDOW_LSB = 10;
	localparam int unsigned MFR_FIFO_DEPTH_WORDS = 1024;
	localparam int unsigned MFR_HALF_WORDS = 512;
	// wait states: first word and each following word of a burst
	localparam logic [2:0] MFR_WAIT_FIRST = 3'h4;
	localparam logic [2:0] MFR_WAIT_NEXT = 3'h1;
	// read clock rises this many cycles after enable goes low
	localparam logic [2:0] MFR_RCLK_DELAY = 3'h1;
	// cycles after the read clock edge before data is sampled
	localparam logic [2:0] MFR_SETTLE_CYCLES = 3'h2;
	// flag refresh pulse follows the address strobe by this many cycles
	localparam logic [1:0] MFR_REFRESH_DELAY = 2'h2;
	localparam logic [2:0] MFR_OE_RST = 3'h7;
	localparam logic [2:0] MFR_RCLK_RST = 3'h0;

	typedef enum logic [2:0] {
		MFR_IDLE = 3'b000,
		MFR_TURN = 3'b001,
		MFR_WAIT = 3'b010,
		MFR_ACK = 3'b011,
		MFR_DONE = 3'b100
	} mfr_state_e;

	function automatic logic [2:0] mfr_onehot(input logic [1:0] idx);
		mfr_onehot = 3'h0;
		if (idx < 2'h3) begin
			mfr_onehot[idx] = 1'b1;
		end
	endfunction
endpackage
`default_nettype wire

// ==== rtl/mfr_word_buf.sv ====
`default_nettype none
module mfr_word_buf import mfr_pkg::*; #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} mfr_buf_s;
	mfr_buf_s st_r, st_nxt;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic push, pop;

	assign in_ready_o = st_r.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = st_r.cnt != '0;
	assign out_data_o = mem_r[st_r.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.wp = st_r.wp + AW'(1);
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + AW'(1);
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// storage has no reset; contents only matter once counted valid
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[st_r.wp] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

// ==== tb/mfr_read_ctrl_props.sv ====
`default_nettype none
module mfr_read_ctrl_props (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic address_strobe_n_i,
	input wire logic write_not_read_i,
	input wire logic [2:0] segment_fifo_output_enable_n_o,
	input wire logic [2:0] segment_fifo_read_clock_o,
	input wire logic ready_n_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic [2:0] oe = segment_fifo_output_enable_n_o;
	wire logic [2:0] rc = segment_fifo_read_clock_o;
	wire logic rn = ready_n_o;
	a_one_enable: assert property ($onehot0(~oe)) else $error("oe");
	a_rclk_delay: assert property ($fell(&oe) |=> rc == ~oe)
		else $error("rclk");
	a_data_settle: assert property ((rc & ~oe) != 3'h0 |-> ##2 !rn)
		else $error("settle");
	a_first_wait: assert property ($fell(&oe) |-> rn[*3] ##1 !rn)
		else $error("wait");
	a_refresh_all: assert property ($fell(address_strobe_n_i) &&
		write_not_read_i |-> ##[2:8] rc == 3'h7) else $error("refresh");
	a_no_pop: assert property (rc == 3'h7 |-> oe == 3'h7)
		else $error("pop");
	a_hold: assert property ($rose(&oe) |-> !$past(rn) || !$past(rn, 2))
		else $error("hold");
	a_ack_pulse: assert property (!rn |=> rn) else $error("ack");
	c_burst: cover property (!rn ##2 !rn ##2 !rn ##2 !rn);
	c_single: cover property ($fell(&oe) ##[3:6] $rose(&oe));
	c_refresh: cover property (rc == 3'h7);
endmodule
bind mfr_read_ctrl mfr_read_ctrl_props u_props (.core_clk_i, .nrst_i,
	.address_strobe_n_i, .write_not_read_i, .segment_fifo_output_enable_n_o,
	.segment_fifo_read_clock_o, .ready_n_o);
`default_nettype wire

// ==== tb/mfr_fifo_chips.sv ====
`default_nettype none
module mfr_fifo_chips (
	input wire logic [2:0] oe_n_i,
	input wire logic [2:0] rclk_i,
	output logic [31:0] data_o,
	output logic [2:0] ef_n_o,
	output logic [2:0] hf_n_o,
	output logic [2:0] ff_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt[3] = '{600, 2, 5};
	int cur = 0;
	logic [15:0] pops[3] = '{0, 0, 0};
	logic [31:0] q[3] = '{0, 0, 0};
	// flags read as empty until the first read clock
	initial {ef_n_o, hf_n_o, ff_n_o} = 9'h03F;
	for (genvar i = 0; i < 3; i++) begin : g_chip
		// pop only with enable low, flags on the rise
		always @(posedge rclk_i[i]) begin
			if (!oe_n_i[i] && cnt[i] > 0) begin
				q[i] = {8'hC0, 6'h0, 2'(i), pops[i]};
				pops[i]++;
				cnt[i]--;
			end
			ef_n_o[i] = cnt[i] != 0;
			hf_n_o[i] = cnt[i] < 512;
			ff_n_o[i] = cnt[i] < 1024;
		end
	end
	always @(oe_n_i) for (int k = 0; k < 3; k++) if (!oe_n_i[k]) cur = k;
	// a released bus shows the inverse of its last word
	assign data_o = &oe_n_i ? ~q[cur] : q[cur];
endmodule
`default_nettype wire

// ==== tb/mfr_read_ctrl_bench.sv ====
`default_nettype none
module mfr_read_ctrl_bench import mfr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, as_n = 1, wr = 0, last = 0, dir = 1, wrdy = 1;
	logic rdy_n, wv, busy;
	logic [2:0] sel = 0, oe, rc, ef, hf, ff, efo, hfo, ffo;
	logic [31:0] addr = 0, bus, wd;
	logic [15:0] seq[3] = '{0, 0, 0};
	logic [31:0] exp_q[$];
	int mismatches = 0, n_checks = 0, cyc = 0, a, t;
	mfr_read_ctrl u_dut (.core_clk_i(clk), .nrst_i(nrst),
		.address_strobe_n_i(as_n), .addr_i(addr), .write_not_read_i(wr),
		.burst_last_i(last), .fifo_region_sel_i(sel),
		.slow_bus_direction_i(dir), .slow_data_i(bus),
		.fifo_empty_flag_n_i(ef), .fifo_half_full_flag_n_i(hf),
		.fifo_full_flag_n_i(ff), .word_ready_i(wrdy),
		.segment_fifo_output_enable_n_o(oe), .segment_fifo_read_clock_o(rc),
		.ready_n_o(rdy_n), .word_data_o(wd), .word_valid_o(wv),
		.fifo_empty_flag_n_o(efo), .fifo_half_full_flag_n_o(hfo),
		.fifo_full_flag_n_o(ffo), .busy_o(busy));
	mfr_fifo_chips u_chips (.oe_n_i(oe), .rclk_i(rc), .data_o(bus),
		.ef_n_o(ef), .hf_n_o(hf), .ff_n_o(ff));
	initial forever #50 clk = ~clk;
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 2000) begin
		mismatches++;
		conclude();
	end
	always @(posedge clk) if (wv === 1'b1 && wrdy)
		chk("word", exp_q.pop_front(), wd);
	// ready returns late only once the buffer is let drain
	task automatic rd(int i, int n);
		a = 0;
		@(negedge clk) as_n = 0;
		wr = 0;
		dir = 0;
		last = n == 1;
		sel = 3'h1 << i;
		addr = 32'h400 * (i + 1);
		@(negedge clk) as_n = 1;
		for (t = 0; t < 80 && a < n; t++) begin
			@(negedge clk) wrdy |= t == 40;
			if (rdy_n === 1'b0) begin
				exp_q.push_back({8'hC0, 6'h0, 2'(i), seq[i]});
				seq[i]++;
				a++;
				addr += 4;
			end
		end
		chk("acks", n, a);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		chk("reset", 9'h1C4, {oe, rc, rdy_n, wv, busy});
		nrst = 1;
		@(negedge clk) as_n = 0;
		wr = 1;
		@(negedge clk) as_n = 1;
		a = 0;
		repeat (12) @(negedge clk) a += (rc === 3'h7) + 4 * (rdy_n === 1'b0);
		chk("refresh", 1, a);
		chk("flags", 9'h1F7, {efo, hfo, ffo});
		$display("test refresh done");
		rd(1, 1);
		rd(1, 1);
		rd(2, 1);
		repeat (2) rd(0, 4);
		$display("test reads done");
		repeat (9) @(negedge clk);
		wrdy = 0;
		repeat (MFR_BUF_DEPTH / 4) rd(0, 4);
		rd(0, 1);
		chk("stall", 1, t > 40);
		repeat (30) @(negedge clk);
		chk("drained", 0, exp_q.size() + seq[0] - 25);
		chk("idle", 0, busy);
		$display("test full buffer done");
		conclude();
	end
endmodule
`default_nettype wire
